/* File: scsl_params.svh */
// Timing and layout constants for the switch control shift latch.
// Assumes a single core clock of 250 MHz; included by bare name.
`ifndef SCSL_PARAMS_SVH
`define SCSL_PARAMS_SVH
`define SCSL_NUM_SWITCH     16
`define SCSL_CORE_CLK_MHZ   250
`define SCSL_SCLK_MAX_MHZ   66
// Half period of the generated shift clock, in core cycles, rounded up
`define SCSL_SCLK_HALF_CYC  ((`SCSL_CORE_CLK_MHZ + 2*`SCSL_SCLK_MAX_MHZ - 1) \
                             / (2*`SCSL_SCLK_MAX_MHZ))
`define SCSL_SHIFT_RST      16'h0000
`define SCSL_LATCH_RST      16'h0000
`endif

/* File: scsl_pkg.sv */
// Types used by the host end and the bench of the switch control shift latch link.
// Assumes scsl_params.svh is on the include path.
`include "scsl_params.svh"
package scsl_pkg;
  typedef logic [`SCSL_NUM_SWITCH-1:0] scsl_word_t;
  typedef enum logic [1:0] {
    SCSL_IDLE  = 2'b00,
    SCSL_SHIFT = 2'b01,
    SCSL_LOAD  = 2'b10,
    SCSL_DONE  = 2'b11
  } scsl_state_e;
endpackage

/* File: scsl_if.sv */
// Serial link between host and switch device.
// Assumes the bench joins two ends; all signals are plain one-way wires.
`timescale 1ns/1ps
interface scsl_if;
  logic sclk;
  logic sdata_in;
  logic sdata_out;
  logic latch_load_n;
  logic latch_clear;
  modport host (output sclk, output sdata_in, output latch_load_n,
                output latch_clear, input sdata_out);
  modport dev  (input sclk, input sdata_in, input latch_load_n,
                input latch_clear, output sdata_out);
endinterface

/* File: scsl_dev.sv */
// Switch device end: shift register, latches and chain output.
// Assumes link pins arrive asynchronously and are sampled on CORE_CLK.
//
// Contract
// R1: Shift correctly with clock up to 66 MHz
// R2: Rising shift clock captures data, advances register
// R3: Host sends switch fifteen first, zero last
// R4: Host holds load high while shifting frame
// R5: Falling load copies whole register to latches
// R6: Latches hold while load high, shifting continues
// R7: Clear high forces all latches low
// R8: Clear never touches the shift register
// R9: Chain output feeds next device input
// R10: Chain of N takes N times 16 edges
// R11: One load pulse updates every device together
// R12: Host may ignore or read back chain output
// R13: Host should update all switches in one load
// R14: Load input is active low
// R15: Chain output is last shift stage
// R16: Latch one closes switch, zero opens
`timescale 1ns/1ps
`include "scsl_params.svh"
module scsl_dev #(
  parameter int NUM_SWITCH = `SCSL_NUM_SWITCH
) (
  // Clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  SRST,
  // Link
  scsl_if.dev                        LINK,
  // Switch controls, one closes the switch
  output logic [NUM_SWITCH-1:0]      SWITCH_CLOSED
);
  // Position of each link pin inside the synchroniser bank
  localparam int PIN_CLEAR = 0;
  localparam int PIN_LOAD  = 1;
  localparam int PIN_DATA  = 2;
  localparam int PIN_SCLK  = 3;
  localparam int NUM_PIN   = 4;
  // Idle level of each pin; reset to it so no false edge follows reset
  localparam logic [NUM_PIN-1:0]    PIN_IDLE  = 4'h2;
  // Reset images of the shift register and the latches
  localparam logic [NUM_SWITCH-1:0] SHIFT_RST = NUM_SWITCH'(`SCSL_SHIFT_RST);
  localparam logic [NUM_SWITCH-1:0] LATCH_RST = NUM_SWITCH'(`SCSL_LATCH_RST);

  // Link pins gathered into one bank
  logic [NUM_PIN-1:0]    pin_raw;
  // Two-stage synchroniser, one pair of flops per pin
  logic                  meta_ff   [NUM_PIN];
  logic                  nxt_meta  [NUM_PIN];
  logic                  sync_ff   [NUM_PIN];
  logic                  nxt_sync  [NUM_PIN];
  // Previous synchronised levels for edge detection
  logic                  sclk_d_ff;
  logic                  nxt_sclk_d;
  logic                  load_d_ff;
  logic                  nxt_load_d;
  logic                  rise;
  logic                  fall;
  // One shift stage and one latch per switch
  logic                  shift_ff  [NUM_SWITCH];
  logic                  nxt_shift [NUM_SWITCH];
  logic                  latch_ff  [NUM_SWITCH];
  logic                  nxt_latch [NUM_SWITCH];
  // Registered chain output
  logic                  sout_ff;
  logic                  nxt_sout;

  // Pins arrive from outside the core clock domain
  assign pin_raw[PIN_CLEAR] = LINK.latch_clear;
  assign pin_raw[PIN_LOAD]  = LINK.latch_load_n;
  assign pin_raw[PIN_DATA]  = LINK.sdata_in;
  assign pin_raw[PIN_SCLK]  = LINK.sclk;

  // Every pin passes two flops before any logic reads it
  for (genvar p = 0; p < NUM_PIN; p++) begin : g_sync
    always_comb begin
      nxt_meta[p] = pin_raw[p];
      nxt_sync[p] = meta_ff[p];
    end

    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        meta_ff[p] <= PIN_IDLE[p];
        sync_ff[p] <= PIN_IDLE[p];
      end else begin
        meta_ff[p] <= nxt_meta[p];
        sync_ff[p] <= nxt_sync[p];
      end
    end
  end

  // Sampling at 250 MHz sees every edge of a 66 MHz shift clock
  always_comb begin
    nxt_sclk_d = sync_ff[PIN_SCLK];
    rise       = sync_ff[PIN_SCLK] & ~sclk_d_ff; // R1
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sclk_d_ff <= PIN_IDLE[PIN_SCLK];
    end else begin
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  // Load is active low: only its falling edge copies the register
  always_comb begin
    nxt_load_d = sync_ff[PIN_LOAD];
    fall       = ~sync_ff[PIN_LOAD] & load_d_ff; // R14
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      load_d_ff <= PIN_IDLE[PIN_LOAD];
    end else begin
      load_d_ff <= nxt_load_d;
    end
  end

  // Stage zero takes the data pin, the others the stage before
  for (genvar i = 0; i < NUM_SWITCH; i++) begin : g_stage
    logic from_prev;

    if (i == 0) begin : g_head
      assign from_prev = sync_ff[PIN_DATA];
    end else begin : g_body
      assign from_prev = shift_ff[i-1];
    end

    // Clear never reaches the shift stage
    always_comb begin
      nxt_shift[i] = shift_ff[i]; // R8
      if (rise) begin
        nxt_shift[i] = from_prev; // R2
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        shift_ff[i] <= SHIFT_RST[i];
      end else begin
        shift_ff[i] <= nxt_shift[i];
      end
    end

    // Clear wins over a load that falls in the same cycle
    always_comb begin
      nxt_latch[i] = latch_ff[i]; // R6
      if (sync_ff[PIN_CLEAR]) begin
        nxt_latch[i] = 1'b0; // R7
      end else if (fall) begin
        nxt_latch[i] = shift_ff[i]; // R5 R11
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        latch_ff[i] <= LATCH_RST[i];
      end else begin
        latch_ff[i] <= nxt_latch[i];
      end
    end

    assign SWITCH_CLOSED[i] = latch_ff[i]; // R16
  end

  // Chain output is the last stage, one flop later
  always_comb begin
    nxt_sout = shift_ff[NUM_SWITCH-1]; // R15
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sout_ff <= 1'b0;
    end else begin
      sout_ff <= nxt_sout;
    end
  end

  assign LINK.sdata_out = sout_ff;
endmodule // scsl_dev

/* File: scsl_host.sv */
// Host end: shifts a chain frame out, then pulses the load low once.
// Assumes the device samples the link; generates the shift clock itself.
`timescale 1ns/1ps
`include "scsl_params.svh"
module scsl_host #(
  parameter int NUM_SWITCH = `SCSL_NUM_SWITCH,
  parameter int NUM_DEV    = 1,
  parameter int HALF_CYC   = `SCSL_SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                          CORE_CLK,
  input  wire logic                          SRST,
  // Link
  scsl_if.host                               LINK,
  // User request
  input  wire logic                          START,
  input  wire logic [NUM_DEV*NUM_SWITCH-1:0] FRAME,
  input  wire logic                          CLEAR,
  output logic                               BUSY,
  output logic                               DONE,
  // Read-back of previous chain contents
  output logic [NUM_DEV*NUM_SWITCH-1:0]      READBACK
);
  localparam int W = NUM_DEV * NUM_SWITCH;
  scsl_pkg::scsl_state_e st_ff, nxt_st;
  logic [W-1:0]  dat_ff, nxt_dat;
  logic [W-1:0]  rb_ff, nxt_rb;
  logic [15:0]   bit_ff, nxt_bit;
  logic [7:0]    div_ff, nxt_div;
  logic          sclk_ff, nxt_sclk;
  logic          sdo_ff, nxt_sdo;
  logic          load_n_ff, nxt_load_n;
  logic          clear_ff, nxt_clear;
  logic          busy_ff, nxt_busy;
  logic          done_ff, nxt_done;
  logic [1:0]    rsync_ff, nxt_rsync;
  logic          tick;

  always_comb begin
    nxt_st     = st_ff;
    nxt_dat    = dat_ff;
    nxt_rb     = rb_ff;
    nxt_bit    = bit_ff;
    nxt_sclk   = sclk_ff;
    nxt_sdo    = sdo_ff;
    nxt_load_n = 1'b1;
    nxt_clear  = CLEAR;
    nxt_done   = 1'b0;
    nxt_rsync  = {rsync_ff[0], LINK.sdata_out};
    // Divider keeps shift clock at or below its top rate // R1
    tick       = (div_ff == 8'(HALF_CYC - 1));
    nxt_div    = tick ? 8'h00 : div_ff + 8'h01;
    case (st_ff)
      scsl_pkg::SCSL_IDLE: begin
        nxt_div = 8'h00;
        if (START) begin
          nxt_st  = scsl_pkg::SCSL_SHIFT;
          nxt_dat = FRAME;
          nxt_sdo = FRAME[W-1]; // R3
          nxt_bit = 16'h0000;
          nxt_clear = 1'b0; // R10
        end
      end
      scsl_pkg::SCSL_SHIFT: begin
        nxt_clear = 1'b0; // R10
        if (tick) begin
          nxt_sclk = ~sclk_ff;
          if (!sclk_ff) begin
            // Chain output arrives one rise late through the syncs,
            // so the first rise is skipped and the load takes the last
            if (bit_ff != 16'h0000) begin
              nxt_rb = {rb_ff[W-2:0], rsync_ff[1]}; // R12
            end
          end else begin
            nxt_dat = {dat_ff[W-2:0], 1'b0};
            nxt_sdo = dat_ff[W-2];
            nxt_bit = bit_ff + 16'h0001;
            if (bit_ff == 16'(W - 1)) begin
              nxt_st = scsl_pkg::SCSL_LOAD; // R4
            end
          end
        end
      end
      scsl_pkg::SCSL_LOAD: begin
        nxt_load_n = 1'b0; // R11 R13
        nxt_clear  = 1'b0;
        if (tick) begin
          nxt_rb = {rb_ff[W-2:0], rsync_ff[1]}; // R12
          nxt_st = scsl_pkg::SCSL_DONE;
        end
      end
      scsl_pkg::SCSL_DONE: begin
        nxt_done = 1'b1;
        nxt_st   = scsl_pkg::SCSL_IDLE;
      end
      default: nxt_st = scsl_pkg::SCSL_IDLE;
    endcase
    nxt_busy = (nxt_st != scsl_pkg::SCSL_IDLE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_ff     <= scsl_pkg::SCSL_IDLE;
      dat_ff    <= '0;
      rb_ff     <= '0;
      bit_ff    <= 16'h0000;
      div_ff    <= 8'h00;
      sclk_ff   <= 1'b0;
      sdo_ff    <= 1'b0;
      load_n_ff <= 1'b1;
      clear_ff  <= 1'b0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      rsync_ff  <= 2'h0;
    end else begin
      st_ff     <= nxt_st;
      dat_ff    <= nxt_dat;
      rb_ff     <= nxt_rb;
      bit_ff    <= nxt_bit;
      div_ff    <= nxt_div;
      sclk_ff   <= nxt_sclk;
      sdo_ff    <= nxt_sdo;
      load_n_ff <= nxt_load_n;
      clear_ff  <= nxt_clear;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
      rsync_ff  <= nxt_rsync;
    end
  end

  assign LINK.sclk         = sclk_ff;
  assign LINK.sdata_in     = sdo_ff; // R9
  assign LINK.latch_load_n = load_n_ff;
  assign LINK.latch_clear  = clear_ff;
  assign BUSY              = busy_ff;
  assign DONE              = done_ff;
  assign READBACK          = rb_ff;
endmodule // scsl_host

/* File: scsl_monitor.sv */
// Checker for the serial switch link, watching the link wires only.
// Assumes it is instantiated beside the interface in the bench.
`timescale 1ns/1ps
module scsl_monitor (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Link
  input wire logic sclk,
  input wire logic sdata_in,
  input wire logic sdata_out,
  input wire logic latch_load_n,
  input wire logic latch_clear
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  property p_clk_high; $rose(sclk) |-> sclk [*2]; endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("clock high too short");
  property p_clk_low; $fell(sclk) |-> !sclk [*2]; endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("clock low too short");
  property p_din_setup; $rose(sclk) |-> $stable(sdata_in); endproperty
  a_din_setup: assert property (p_din_setup)
    else $error("data moved at clock rise");
  property p_load_shift; $rose(sclk) |-> latch_load_n; endproperty
  a_load_shift: assert property (p_load_shift)
    else $error("load low while shifting");
  property p_clear_shift; $rose(sclk) |-> !latch_clear; endproperty
  a_clear_shift: assert property (p_clear_shift)
    else $error("clear high while shifting");
  // One pulse of two core cycles, so every chained device sees it
  property p_load_pulse;
    $fell(latch_load_n) |-> !latch_load_n [*2] ##1 latch_load_n;
  endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("load pulse width wrong");
  property p_dout_when;
    $changed(sdata_out) |-> $past(sclk, 3) || $past(sclk, 4);
  endproperty
  a_dout_when: assert property (p_dout_when)
    else $error("chain output moved off a shift");
  property p_clear_idle; $rose(latch_clear) |-> latch_load_n && !sclk;
  endproperty
  a_clear_idle: assert property (p_clear_idle)
    else $error("clear raised mid frame");
  c_shift: cover property ($rose(sclk));
  c_load: cover property ($fell(latch_load_n));
  c_clear: cover property ($rose(latch_clear));
endmodule // scsl_monitor

/* File: switch_control_shift_latch_tb.sv */
// Bench joining the host and device ends of the serial switch link.
// Assumes scsl_params.svh, the package and the design are compiled first.
`timescale 1ns/1ps
module switch_control_shift_latch_tb;
  logic                 clk         = 1'b0;
  logic                 srst        = 1'b1;
  logic                 start       = 1'b0;
  logic                 clear_req   = 1'b0;
  scsl_pkg::scsl_word_t frame       = 16'h0000;
  scsl_pkg::scsl_word_t last        = 16'h0000;
  scsl_pkg::scsl_word_t rb;
  scsl_pkg::scsl_word_t sw;
  logic                 busy;
  logic                 done;
  int                   bad_count   = 0;
  int                   checks_done = 0;
  scsl_if link ();
  always #2 clk = ~clk;
  scsl_host scsl_host_i (.CORE_CLK(clk), .SRST(srst), .LINK(link.host),
    .START(start), .FRAME(frame), .CLEAR(clear_req), .BUSY(busy),
    .DONE(done),
    .READBACK(rb));
  scsl_dev scsl_dev_i (.CORE_CLK(clk), .SRST(srst), .LINK(link.dev),
    .SWITCH_CLOSED(sw));
  scsl_monitor scsl_monitor_i (.CORE_CLK(clk), .SRST(srst),
    .sclk(link.sclk), .sdata_in(link.sdata_in),
    .sdata_out(link.sdata_out), .latch_load_n(link.latch_load_n),
    .latch_clear(link.latch_clear));
  task automatic chk(input scsl_pkg::scsl_word_t got,
                     input scsl_pkg::scsl_word_t exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp,
                         input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Sample on the falling edge so design updates have landed
  task automatic send(input scsl_pkg::scsl_word_t f,
                      input scsl_pkg::scsl_word_t exp_rb);
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    frame <= f;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(negedge clk);
    chk(sw, last, "hold mid frame");
    chk_bit(busy, 1'b1, "busy mid frame");
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      $display("ERROR at %0t: no done pulse", $time);
    end
    repeat (4) @(negedge clk);
    chk(sw, f, "latched");
    chk_bit(busy, 1'b0, "busy after done");
    chk(rb, exp_rb, "readback");
    last = f;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(sw, 16'h0000, "reset");
    send(16'hA5C3, 16'h0000);
    send(16'h8001, 16'hA5C3);
    @(posedge clk);
    clear_req <= 1'b1;
    repeat (8) @(negedge clk);
    chk(sw, 16'h0000, "clear");
    @(posedge clk);
    clear_req <= 1'b0;
    repeat (8) @(negedge clk);
    chk(sw, 16'h0000, "after clear");
    last = 16'h0000;
    send(16'h0F0F, 16'h8001);
    send(16'hFFFF, 16'h0F0F);
    finish_test();
  end
  // Four frames take under 2 us
  initial begin
    #20000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // switch_control_shift_latch_tb
